// *** bench/ip_slot_model.sv ***
`timescale 1ns/10ps
module ip_slot_model (
   input  wire logic        ref_clk,
   input  wire logic [2:0]  ipSel_n,
   input  wire logic [2:0]  mute,
   output logic      [2:0]  ipAck_n,
   output logic      [15:0] ipDataIn
);
   logic [2:0] who;
   int         cnt;
   int         hold;
   initial begin
      ipAck_n = 3'h7;
      ipDataIn = 16'h0000;
      who = 3'h0;
      cnt = 0;
      hold = 0;
   end
   // fixed answer delay; a muted slot never acknowledges, data churns when idle
   always @(posedge ref_clk) begin
      ipAck_n <= 3'h7;
      if (hold > 0)
         hold <= hold - 1;
      else
         ipDataIn <= ~ipDataIn;
      if (cnt == 0 && (~ipSel_n & ~mute) != 3'h0) begin
         who <= ~ipSel_n & ~mute;
         cnt <= 1;
         hold <= 12;
         ipDataIn <= 16'hA53C;
      end else if (cnt == 3) begin
         ipAck_n <= ~who;
         cnt <= 4;
         hold <= 6;
      end else if (cnt == 4) begin
         if (ipSel_n == 3'h7)
            cnt <= 0;
      end else if (cnt > 0)
         cnt <= cnt + 1;
   end
endmodule

// *** bench/tb_ip_carrier_slot_control.sv ***
`timescale 1ns/10ps
`include "ipc_consts.svh"
module tb_ip_carrier_slot_control;
   import ipc_pkg::*;
   logic        ref_clk;
   logic        srst;
   logic [1:0]  lbWindow;
   logic [24:0] lbAddr;
   logic        lbRd;
   logic        lbWr;
   logic [15:0] lbWrData;
   logic [15:0] lbRdData;
   logic        lbAck;
   logic        local_irq_out_n;
   logic        payloadRst_n;
   logic        moduleReset_n;
   logic [2:0]  slotClkTick;
   logic [2:0]  ipSel_n;
   logic [2:0]  ipAck_n;
   logic [5:0]  ipIrq_n;
   logic [2:0]  ipErr_n;
   logic [2:0]  mute;
   logic [15:0] ipDataIn;
   logic [22:0] ipAddr;
   ip_space_t   ipSpace;
   logic        ipWrite;
   logic [15:0] ipDataOut;
   logic        ipDataOe;
   logic [35:0] seen;
   int          fails;
   int          check_count;
   int          cycles;

   ip_carrier_slot_control u_ip_carrier_slot_control (
      .ref_clk(ref_clk), .srst(srst), .lbWindow(lbWindow), .lbAddr(lbAddr),
      .lbRd(lbRd), .lbWr(lbWr), .lbWrData(lbWrData), .lbRdData(lbRdData),
      .lbAck(lbAck), .local_irq_out_n(local_irq_out_n), .payloadRst_n(payloadRst_n),
      .moduleReset_n(moduleReset_n), .slotClkTick(slotClkTick), .ipSel_n(ipSel_n),
      .ipAck_n(ipAck_n), .ipIrq_n(ipIrq_n), .ipErr_n(ipErr_n), .ipAddr(ipAddr),
      .ipSpace(ipSpace), .ipWrite(ipWrite), .ipDataOut(ipDataOut), .ipDataOe(ipDataOe),
      .ipDataIn(ipDataIn));

   ip_slot_model u_ip_slot_model (
      .ref_clk(ref_clk), .ipSel_n(ipSel_n), .mute(mute), .ipAck_n(ipAck_n),
      .ipDataIn(ipDataIn));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic bus(input logic [1:0] win, input logic [24:0] a, input logic wr,
                      input logic [15:0] wd, output logic [15:0] rd, output int selN,
                      output int waitN);
      int n;
      @(posedge ref_clk);
      lbWindow <= win;
      lbAddr <= a;
      lbWrData <= wd;
      lbWr <= wr;
      lbRd <= !wr;
      @(posedge ref_clk);
      lbWr <= 1'b0;
      lbRd <= 1'b0;
      selN = 0;
      waitN = 0;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
         if (ipSel_n !== 3'h7) begin
            if (selN == 0)
               seen = {ipDataOe, ipWrite, ipSpace, ipDataOut, ipAddr[15:0]};
            selN++;
         end else if (selN == 0)
            waitN++;
      end while (lbAck !== 1'b1 && n < 1000);
      if (n >= 1000)
         chk("lbAck", 16'h0001, 16'h0000);
      rd = lbRdData;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [15:0] d);
      int s, w;
      bus(2'h0, {17'h0, a}, 1'b0, 16'h0000, d, s, w);
   endtask

   task automatic wreg(input logic [7:0] a, input logic [15:0] v);
      logic [15:0] d;
      int s, w;
      bus(2'h0, {17'h0, a}, 1'b1, v, d, s, w);
   endtask

   task automatic t_regs;
      logic [15:0] d;
      rreg(8'h00, d);
      chk("revision", {8'h00, `LOGIC_REV}, d);
      wreg(8'h00, 16'h5A5A);
      rreg(8'h00, d);
      chk("revisionWritten", {8'h00, `LOGIC_REV}, d);
      for (int s = 0; s < 3; s++) begin
         rreg(8'h02 + 8'(2 * s), d);
         chk("controlReset", 16'h0000, d);
         wreg(8'h02 + 8'(2 * s), 16'hFE00 | 16'(s + 1));
      end
      for (int s = 0; s < 3; s++) begin
         rreg(8'h02 + 8'(2 * s), d);
         chk("controlValue", 16'(s + 1), d);
      end
      wreg(8'h08, 16'hFFFF);
      rreg(8'h08, d);
      chk("reservedOffset", 16'h0000, d);
      for (int s = 0; s < 3; s++)
         wreg(8'h02 + 8'(2 * s), 16'h0000);
   endtask

   task automatic t_reset;
      logic [15:0] d;
      wreg(8'h0A, 16'h0000);
      rreg(8'h0A, d);
      chk("resetIdle", 16'h0000, d);
      wreg(8'h0A, 16'h0001);
      rreg(8'h0A, d);
      chk("resetBit", 16'h0001, d);
      chk("resetPin", 16'h0000, {15'h0, moduleReset_n});
      repeat (420) @(posedge ref_clk);
      rreg(8'h0A, d);
      chk("resetDone", 16'h0000, d);
      chk("resetPinDone", 16'h0001, {15'h0, moduleReset_n});
      @(posedge ref_clk);
      payloadRst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rreg(8'h0A, d);
      chk("payloadBit", 16'h0001, d);
      chk("payloadPin", 16'h0000, {15'h0, moduleReset_n});
      @(posedge ref_clk);
      payloadRst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rreg(8'h0A, d);
      chk("payloadOff", 16'h0000, d);
   endtask

   task automatic t_clock;
      int n;
      for (int f = 0; f < 2; f++) begin
         wreg(8'h02, 16'(f));
         repeat (8) @(negedge ref_clk);
         n = 0;
         repeat (400) begin
            @(negedge ref_clk);
            if (slotClkTick[0] === 1'b1)
               n++;
         end
         chk("tickRate", 16'h0001, 16'(n >= (f ? 319 : 79) && n <= (f ? 321 : 81)));
      end
   endtask

   task automatic t_cycles;
      logic [15:0] d;
      int          sn;
      int          wn;
      int          c0;
      for (int m = 0; m < 2; m++) begin
         wreg(8'h02, m ? 16'h0103 : 16'h0001);
         bus(2'h2, 25'h0, 1'b0, 16'h0000, d, sn, wn);
         chk("memRead", 16'hA53C, d);
         chk("selectLength", 16'h0001, 16'(m ? sn >= 4 : sn <= 2));
         bus(2'h2, 25'h0, 1'b0, 16'h0000, d, sn, wn);
         chk("selectDelay", 16'h0001, 16'(m ? wn >= 30 : wn <= 4));
      end
      wreg(8'h02, 16'h0000);
      bus(2'h1, 25'h0, 1'b0, 16'h0000, d, sn, wn);
      chk("ioRead", 16'hA53C, d);
      bus(2'h3, 25'h0400000, 1'b0, 16'h0000, d, sn, wn);
      chk("byteRead", 16'h003C, d);
      bus(2'h2, 25'h1800000, 1'b0, 16'h0000, d, sn, wn);
      chk("reservedSlot", 16'hFFFF, d);
      chk("reservedNoSelect", 16'h0000, 16'(sn));
      @(posedge ref_clk);
      mute <= 3'h4;
      c0 = cycles;
      bus(2'h2, 25'h1000000, 1'b0, 16'h0000, d, sn, wn);
      chk("timeoutData", 16'hFFFF, d);
      chk("timeoutLength", 16'h0001, 16'(cycles - c0 >= 318 && cycles - c0 <= 335));
      rreg(8'h0C, d);
      chk("timeoutFlag", 16'h4000, d);
      chk("timeoutIrqBlocked", 16'h0001, {15'h0, local_irq_out_n});
      wreg(8'h06, 16'h0004);
      rreg(8'h0C, d);
      chk("timeoutIrq", 16'h0000, {15'h0, local_irq_out_n});
      wreg(8'h0C, 16'h3000);
      rreg(8'h0C, d);
      chk("timeoutKept", 16'h4000, d);
      wreg(8'h0C, 16'h4000);
      rreg(8'h0C, d);
      chk("timeoutCleared", 16'h0000, d);
      chk("timeoutIrqOff", 16'h0001, {15'h0, local_irq_out_n});
      wreg(8'h06, 16'h0000);
      mute <= 3'h0;
   endtask

   task automatic t_write;
      logic [15:0] d;
      int          sn, wn;
      bus(2'h1, 25'h0000142, 1'b1, 16'h1234, d, sn, wn);
      chk("ipAddr", 16'h0042, seen[15:0]);
      chk("ipDataOut", 16'h1234, seen[31:16]);
      chk("ipWriteIo", 16'h000C, {12'h0, seen[35:32]});
      bus(2'h1, 25'h00001C2, 1'b0, 16'h0000, d, sn, wn);
      chk("ipReadInt", 16'h0002, {12'h0, seen[35:32]});
   endtask

   task automatic t_irq;
      logic [15:0] d;
      @(posedge ref_clk);
      ipErr_n <= 3'h3;
      repeat (5) @(posedge ref_clk);
      rreg(8'h0C, d);
      chk("errorLine", 16'h0400, d);
      chk("errorIrqBlocked", 16'h0001, {15'h0, local_irq_out_n});
      wreg(8'h06, 16'h0008);
      wreg(8'h0C, 16'h0400);
      rreg(8'h0C, d);
      chk("errorKept", 16'h0400, d);
      chk("errorIrq", 16'h0000, {15'h0, local_irq_out_n});
      wreg(8'h06, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         ipErr_n <= 3'h7;
         ipIrq_n <= ~(6'h01 << k);
         repeat (5) @(posedge ref_clk);
         rreg(8'h0C, d);
         chk("levelStatus", 16'(1 << k), d);
         chk("irqDisabled", 16'h0001, {15'h0, local_irq_out_n});
         wreg(8'h02, 16'(16'h0040 << k));
         rreg(8'h0C, d);
         chk("irqEnabled", 16'h0000, {15'h0, local_irq_out_n});
         @(posedge ref_clk);
         ipIrq_n <= 6'h3F;
         repeat (5) @(posedge ref_clk);
         rreg(8'h0C, d);
         chk("levelFollows", 16'h0000, d);
         wreg(8'h02, 16'(16'h0050 << k));
         @(posedge ref_clk);
         ipIrq_n <= ~(6'h01 << k);
         repeat (3) @(posedge ref_clk);
         ipIrq_n <= 6'h3F;
         repeat (5) @(posedge ref_clk);
         rreg(8'h0C, d);
         chk("edgeLatched", 16'(1 << k), d);
         chk("edgeIrq", 16'h0000, {15'h0, local_irq_out_n});
         wreg(8'h0C, 16'h0000);
         rreg(8'h0C, d);
         chk("edgeKept", 16'(1 << k), d);
         wreg(8'h0C, 16'(1 << k));
         rreg(8'h0C, d);
         chk("edgeCleared", 16'h0000, d);
         chk("irqReleased", 16'h0001, {15'h0, local_irq_out_n});
         wreg(8'h02, 16'h0000);
      end
   endtask

   initial begin
      srst = 1'b1;
      lbWindow = 2'h0;
      lbAddr = 25'h0;
      lbRd = 1'b0;
      lbWr = 1'b0;
      lbWrData = 16'h0000;
      payloadRst_n = 1'b1;
      ipIrq_n = 6'h3F;
      ipErr_n = 3'h7;
      mute = 3'h0;
      fails = 0;
      check_count = 0;
      cycles = 0;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      t_regs();
      t_reset();
      t_clock();
      t_cycles();
      t_write();
      t_irq();
      print_verdict();
   end
endmodule

// *** rtl/ip_carrier_slot_control.sv ***
// Notes on behaviour
// - control bit 0 picks 8 or 32 MHz
// - recovery bit delays next cycle about 1us
// - bit 2 lets timeout raise interrupt
// - bit 3 lets error line raise interrupt
// - bits 4,5 choose level or edge sensing
// - bits 6,7 enable interrupt lines 0,1
// - bit 8 holds select until first acknowledge
// - reset clears controls; bits 15..9 ignored
// - three control registers at 0x02, 0x04, 0x06
// - offset 0x00 reads revision, writes ignored
// - writing 1 pulses module reset, self-clearing
// - reset bit reads 1 while reset asserted
// - payload reset also asserts module reset
// - status 12..14 latch timeouts, write-1 clears
// - four local windows, register, io, memories
// - no acknowledge in 8us ends cycle, ones
// - status 8..10 show live error lines
// - status 0..5 show requests, write-1 clears edge-latched bits only
// - interrupt out when enabled status bit set
`timescale 1ns/10ps
`include "ipc_consts.svh"
module ip_carrier_slot_control
   import ipc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic [1:0]  lbWindow,
   input  wire logic [24:0] lbAddr,
   input  wire logic        lbRd,
   input  wire logic        lbWr,
   input  wire logic [15:0] lbWrData,
   output logic      [15:0] lbRdData,
   output logic             lbAck,
   output logic             local_irq_out_n,
   input  wire logic        payloadRst_n,
   output logic             moduleReset_n,
   output logic [2:0]       slotClkTick,
   output logic [2:0]       ipSel_n,
   input  wire logic [2:0]  ipAck_n,
   input  wire logic [5:0]  ipIrq_n,
   input  wire logic [2:0]  ipErr_n,
   output logic [22:0]      ipAddr,
   output ip_space_t        ipSpace,
   output logic             ipWrite,
   output logic [15:0]      ipDataOut,
   output logic             ipDataOe,
   input  wire logic [15:0] ipDataIn
);
   // pin synchronisers
   logic [2:0]        ackS1, ackS2;
   logic [5:0]        irqS1, irqS2;
   logic [2:0]        errS1, errS2;
   logic              prstS1, prstS2;
   logic [15:0]       datS1, datS2;

   // register group
   slot_ctl_t         ctl [`NSLOT];
   slot_ctl_t         next_ctl [`NSLOT];
   logic [`CNT_W-1:0] mrstCnt, next_mrstCnt;
   logic [5:0]        edgeLatch, next_edgeLatch;
   logic [2:0]        tmoFlag, next_tmoFlag;
   logic [5:0]        irqPrev;
   logic              next_irqOut_n;
   logic              next_moduleReset_n;

   // bus group
   logic              pend, next_pend;
   logic [1:0]        pendSlot, next_pendSlot;
   logic              mem8, next_mem8;
   logic [2:0]        start, next_start;
   logic [15:0]       next_lbRdData;
   logic              next_lbAck;
   logic [22:0]       next_ipAddr;
   ip_space_t         next_ipSpace;
   logic              next_ipWrite;
   logic [15:0]       next_ipDataOut;

   // derived
   logic [2:0]        engDone, engTmo;
   logic [5:0]        irqStat;
   logic [2:0]        errLive;
   logic [15:0]       statWord;
   logic              anyIrq;
   logic              mrstActive;
   logic              regWr, regRd;
   logic [1:0]        reqSlot;
   logic [22:0]       reqAddr;
   ip_space_t         reqSpace;

   slot_if sl [`NSLOT] ();

   genvar g;
   for (g = 0; g < `NSLOT; g++) begin : gSlot
      assign sl[g].ctl     = ctl[g];
      assign sl[g].tick    = slotClkTick[g];
      assign sl[g].start   = start[g];
      assign sl[g].ackSeen = ~ackS2[g];
      assign engDone[g]    = sl[g].done;
      assign engTmo[g]     = sl[g].done & sl[g].timedOut;
      assign ipSel_n[g]    = ~sl[g].sel;
      slot_clock_gen u_slot_clock_gen (
         .ref_clk (ref_clk),
         .srst    (srst),
         .fast    (ctl[g][`CTL_CLK]),
         .tick    (slotClkTick[g])
      );
      slot_engine u_slot_engine (
         .ref_clk (ref_clk),
         .srst    (srst),
         .sl      (sl[g])
      );
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ackS1  <= '1;
         ackS2  <= '1;
         irqS1  <= '1;
         irqS2  <= '1;
         errS1  <= '1;
         errS2  <= '1;
         prstS1 <= 1'b0;
         prstS2 <= 1'b0;
         datS1  <= '0;
         datS2  <= '0;
      end else begin
         ackS1  <= ipAck_n;
         ackS2  <= ackS1;
         irqS1  <= ipIrq_n;
         irqS2  <= irqS1;
         errS1  <= ipErr_n;
         errS2  <= errS1;
         prstS1 <= ~payloadRst_n;
         prstS2 <= prstS1;
         datS1  <= ipDataIn;
         datS2  <= datS1;
      end
   end

   assign regWr      = lbWr && !pend && lbWindow == `SP_REG;
   assign regRd      = lbRd && !pend && lbWindow == `SP_REG;
   assign mrstActive = (mrstCnt != '0) || prstS2;
   assign errLive    = ~errS2;
   assign ipDataOe   = pend && ipWrite;

   // status word and interrupt merge
   always_comb begin
      anyIrq   = 1'b0;
      statWord = '0;
      for (int k = 0; k < 2 * `NSLOT; k++) begin
         irqStat[k] = ctl[k / 2][`CTL_EDGE0 + k % 2] ? edgeLatch[k] : ~irqS2[k];
      end
      statWord[5:0] = irqStat;
      statWord[`STAT_ERR +: `NSLOT] = errLive;
      statWord[`STAT_TMO +: `NSLOT] = tmoFlag;
      for (int s = 0; s < `NSLOT; s++) begin
         anyIrq |= irqStat[2 * s] & ctl[s][`CTL_IRQ_EN0];
         anyIrq |= irqStat[2 * s + 1] & ctl[s][`CTL_IRQ_EN0 + 1];
         anyIrq |= tmoFlag[s] & ctl[s][`CTL_TMO_EN];
         anyIrq |= errLive[s] & ctl[s][`CTL_ERR_EN];
      end
   end

   always_comb begin
      next_ctl       = ctl;
      next_mrstCnt   = (mrstCnt != '0) ? mrstCnt - 1'b1 : mrstCnt;
      next_edgeLatch = edgeLatch;
      next_tmoFlag   = tmoFlag;
      if (regWr) begin
         unique case (lbAddr[7:0])
            `OFS_CTL_A: next_ctl[0] = lbWrData[`CTL_W-1:0];
            `OFS_CTL_B: next_ctl[1] = lbWrData[`CTL_W-1:0];
            `OFS_CTL_C: next_ctl[2] = lbWrData[`CTL_W-1:0];
            `OFS_MRST: begin
               if (lbWrData[0]) begin
                  next_mrstCnt = `CNT_W'(`MRST_CYC);
               end
            end
            `OFS_STAT: begin
               next_edgeLatch = edgeLatch & ~lbWrData[5:0];
               next_tmoFlag   = tmoFlag & ~lbWrData[`STAT_TMO +: `NSLOT];
            end
            default: ;
         endcase
      end
      for (int k = 0; k < 2 * `NSLOT; k++) begin
         if (ctl[k / 2][`CTL_EDGE0 + k % 2] && irqPrev[k] && !irqS2[k]) begin
            next_edgeLatch[k] = 1'b1;
         end
      end
      next_tmoFlag       = next_tmoFlag | engTmo;
      next_moduleReset_n = !((next_mrstCnt != '0) || prstS2);
      next_irqOut_n      = !anyIrq;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctl             <= '{default: '0};
         mrstCnt         <= '0;
         edgeLatch       <= '0;
         tmoFlag         <= '0;
         irqPrev         <= '1;
         local_irq_out_n <= 1'b1;
         moduleReset_n   <= 1'b0;
      end else begin
         ctl             <= next_ctl;
         mrstCnt         <= next_mrstCnt;
         edgeLatch       <= next_edgeLatch;
         tmoFlag         <= next_tmoFlag;
         irqPrev         <= irqS2;
         local_irq_out_n <= next_irqOut_n;
         moduleReset_n   <= next_moduleReset_n;
      end
   end

   always_comb begin
      reqSlot  = lbAddr[`MEM8_SLOT +: 2];
      reqAddr  = {1'b0, lbAddr[`MEM8_SLOT-1:0]};
      reqSpace = SPACE_MEM;
      unique case (lbWindow)
         `SP_IO: begin
            reqSlot  = lbAddr[`IO_SLOT +: 2];
            reqAddr  = {16'h0000, lbAddr[`IO_AW-1:0]};
            reqSpace = !lbAddr[`IO_AW] ? SPACE_IO :
                       (lbAddr[`IO_AW-1] ? SPACE_INT : SPACE_ID);
         end
         `SP_MEM: begin
            reqSlot = lbAddr[`MEM_SLOT +: 2];
            reqAddr = lbAddr[`MEM_SLOT-1:0];
         end
         default: ;
      endcase
   end

   always_comb begin
      next_pend      = pend;
      next_pendSlot  = pendSlot;
      next_mem8      = mem8;
      next_start     = '0;
      next_lbRdData  = lbRdData;
      next_lbAck     = 1'b0;
      next_ipAddr    = ipAddr;
      next_ipSpace   = ipSpace;
      next_ipWrite   = ipWrite;
      next_ipDataOut = ipDataOut;
      if (regRd || regWr) begin
         next_lbAck    = 1'b1;
         next_lbRdData = '0;
         if (regRd) begin
            unique case (lbAddr[7:0])
               `OFS_REV:   next_lbRdData = {8'h00, `LOGIC_REV};
               `OFS_CTL_A: next_lbRdData = {7'h00, ctl[0]};
               `OFS_CTL_B: next_lbRdData = {7'h00, ctl[1]};
               `OFS_CTL_C: next_lbRdData = {7'h00, ctl[2]};
               `OFS_MRST:  next_lbRdData = {15'h0000, mrstActive};
               `OFS_STAT:  next_lbRdData = statWord;
               default:    next_lbRdData = '0;
            endcase
         end
      end else if ((lbRd || lbWr) && !pend) begin
         if (reqSlot == `NO_SLOT) begin
            next_lbAck    = 1'b1;
            next_lbRdData = `ONES;
         end else begin
            next_pend          = 1'b1;
            next_pendSlot      = reqSlot;
            next_mem8          = (lbWindow == `SP_MEM8);
            next_start[reqSlot] = 1'b1;
            next_ipAddr        = reqAddr;
            next_ipSpace       = reqSpace;
            next_ipWrite       = lbWr;
            next_ipDataOut     = lbWrData;
         end
      end else if (pend && engDone[pendSlot]) begin
         next_pend  = 1'b0;
         next_lbAck = 1'b1;
         if (engTmo[pendSlot]) begin
            next_lbRdData = `ONES;
         end else if (mem8) begin
            next_lbRdData = {8'h00, datS2[7:0]};
         end else begin
            next_lbRdData = datS2;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pend      <= 1'b0;
         pendSlot  <= '0;
         mem8      <= 1'b0;
         start     <= '0;
         lbRdData  <= '0;
         lbAck     <= 1'b0;
         ipAddr    <= '0;
         ipSpace   <= SPACE_IO;
         ipWrite   <= 1'b0;
         ipDataOut <= '0;
      end else begin
         pend      <= next_pend;
         pendSlot  <= next_pendSlot;
         mem8      <= next_mem8;
         start     <= next_start;
         lbRdData  <= next_lbRdData;
         lbAck     <= next_lbAck;
         ipAddr    <= next_ipAddr;
         ipSpace   <= next_ipSpace;
         ipWrite   <= next_ipWrite;
         ipDataOut <= next_ipDataOut;
      end
   end

   property p_ctl_reset;
      @(posedge ref_clk) srst |=> (ctl[0] == '0 && ctl[1] == '0 && ctl[2] == '0);
   endproperty
   a_ctl_reset: assert property (p_ctl_reset) else $error("controls not cleared");

   property p_rev_read;
      @(posedge ref_clk) disable iff (srst)
      (regRd && lbAddr[7:0] == `OFS_REV) |=> (lbAck && lbRdData[7:0] == `LOGIC_REV);
   endproperty
   a_rev_read: assert property (p_rev_read) else $error("revision read wrong");

   property p_mrst_pulse;
      @(posedge ref_clk) disable iff (srst)
      (regWr && lbAddr[7:0] == `OFS_MRST && lbWrData[0]) |=> (!moduleReset_n) [*8];
   endproperty
   a_mrst_pulse: assert property (p_mrst_pulse) else $error("module reset not held");

   property p_payload_rst;
      @(posedge ref_clk) disable iff (srst)
      prstS2 |-> (mrstActive ##1 !moduleReset_n);
   endproperty
   a_payload_rst: assert property (p_payload_rst) else $error("payload reset missed");

   property p_tmo_flag;
      @(posedge ref_clk) disable iff (srst)
      engTmo[2] |=> (tmoFlag[2] ##1 (tmoFlag[2] || $past(regWr)));
   endproperty
   a_tmo_flag: assert property (p_tmo_flag) else $error("timeout flag lost");

   property p_no_enable;
      @(posedge ref_clk) disable iff (srst)
      ((ctl[0] | ctl[1] | ctl[2]) & `CTL_W'(9'h0CC)) == '0 |=> local_irq_out_n;
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("interrupt without enable");
endmodule

// *** rtl/ipc_consts.svh ***
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH
`define CLK_NS      25
`define RECOV_NS    1000
`define RECOV_CYC   ((`RECOV_NS + `CLK_NS - 1) / `CLK_NS)
`define TMO_NS      8000
`define TMO_CYC     (`TMO_NS / `CLK_NS)
`define MRST_NS     10000
`define MRST_CYC    (`MRST_NS / `CLK_NS)
`define CNT_W       10
`define NSLOT       3
`define REF_MHZ     6'h28
`define SLOW_MHZ    6'h08
`define FAST_MHZ    6'h20
`define LOGIC_REV   8'h01
`define OFS_REV     8'h00
`define OFS_CTL_A   8'h02
`define OFS_CTL_B   8'h04
`define OFS_CTL_C   8'h06
`define OFS_MRST    8'h0A
`define OFS_STAT    8'h0C
`define CTL_W       9
`define CTL_CLK     0
`define CTL_RECOV   1
`define CTL_TMO_EN  2
`define CTL_ERR_EN  3
`define CTL_EDGE0   4
`define CTL_IRQ_EN0 6
`define CTL_SELX    8
`define STAT_ERR    8
`define STAT_TMO    12
`define SP_REG      2'h0
`define SP_IO       2'h1
`define SP_MEM      2'h2
`define SP_MEM8     2'h3
`define IO_SLOT     8
`define IO_AW       7
`define MEM_SLOT    23
`define MEM8_SLOT   22
`define NO_SLOT     2'h3
`define ONES        16'hFFFF
`endif

// *** rtl/ipc_pkg.sv ***
`include "ipc_consts.svh"
package ipc_pkg;
   typedef enum {CYC_IDLE, CYC_RECOV, CYC_SEL, CYC_WAIT} cyc_state_t;
   typedef enum logic [1:0] {SPACE_IO, SPACE_ID, SPACE_INT, SPACE_MEM} ip_space_t;
   typedef logic [`CTL_W-1:0] slot_ctl_t;
endpackage

// *** rtl/slot_clock_gen.sv ***
`timescale 1ns/10ps
`include "ipc_consts.svh"
module slot_clock_gen (
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic fast,
   output logic      tick
);
   logic [5:0] acc,  next_acc;
   logic [6:0] sum;
   logic       next_tick;

   always_comb begin
      sum       = {1'b0, acc} + {1'b0, (fast ? `FAST_MHZ : `SLOW_MHZ)};
      next_acc  = sum[5:0];
      next_tick = 1'b0;
      if (sum >= {1'b0, `REF_MHZ}) begin
         next_acc  = 6'(sum - {1'b0, `REF_MHZ});
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         acc  <= '0;
         tick <= 1'b0;
      end else begin
         acc  <= next_acc;
         tick <= next_tick;
      end
   end

   property p_slow_spacing;
      @(posedge ref_clk) disable iff (srst)
      (tick && !fast) |=> (!tick || fast) [*4];
   endproperty
   a_slow_spacing: assert property (p_slow_spacing) else $error("slow tick too close");
endmodule

// *** rtl/slot_engine.sv ***
`timescale 1ns/10ps
`include "ipc_consts.svh"
module slot_engine
   import ipc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   slot_if.eng      sl
);
   cyc_state_t        state,  next_state;
   logic [`CNT_W-1:0] recCnt, next_recCnt;
   logic [`CNT_W-1:0] tmoCnt, next_tmoCnt;
   logic              done,   next_done;
   logic              tmo,    next_tmo;
   logic              tmoHit;

   assign tmoHit      = (tmoCnt == `CNT_W'(`TMO_CYC - 1));
   assign sl.sel      = (state == CYC_SEL);
   assign sl.done     = done;
   assign sl.timedOut = tmo;

   always_comb begin
      next_state  = state;
      next_recCnt = (recCnt != '0) ? recCnt - 1'b1 : recCnt;
      next_tmoCnt = '0;
      next_done   = 1'b0;
      next_tmo    = 1'b0;
      unique case (state)
         CYC_IDLE: begin
            if (sl.start) begin
               if (sl.ctl[`CTL_RECOV] && recCnt != '0) begin
                  next_state = CYC_RECOV;
               end else begin
                  next_state = CYC_SEL;
               end
            end
         end
         CYC_RECOV: begin
            if (recCnt == '0) begin
               next_state = CYC_SEL;
            end
         end
         CYC_SEL, CYC_WAIT: begin
            next_tmoCnt = tmoCnt + 1'b1;
            if (sl.ackSeen || tmoHit) begin
               next_done   = 1'b1;
               next_tmo    = !sl.ackSeen;
               next_state  = CYC_IDLE;
               next_recCnt = `CNT_W'(`RECOV_CYC);
               next_tmoCnt = '0;
            end else if (state == CYC_SEL && !sl.ctl[`CTL_SELX] && sl.tick) begin
               next_state = CYC_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state  <= CYC_IDLE;
         recCnt <= '0;
         tmoCnt <= '0;
         done   <= 1'b0;
         tmo    <= 1'b0;
      end else begin
         state  <= next_state;
         recCnt <= next_recCnt;
         tmoCnt <= next_tmoCnt;
         done   <= next_done;
         tmo    <= next_tmo;
      end
   end

   property p_recov_wait;
      @(posedge ref_clk) disable iff (srst)
      ($rose(sl.sel) && sl.ctl[`CTL_RECOV]) |-> ($past(recCnt) <= 1);
   endproperty
   a_recov_wait: assert property (p_recov_wait) else $error("select before recovery");

   property p_single_sel;
      @(posedge ref_clk) disable iff (srst)
      (sl.sel && !sl.ctl[`CTL_SELX] && sl.tick && !sl.ackSeen) |=> !sl.sel;
   endproperty
   a_single_sel: assert property (p_single_sel) else $error("single select too long");

   property p_ext_sel;
      @(posedge ref_clk) disable iff (srst)
      (sl.sel && sl.ctl[`CTL_SELX] && !sl.ackSeen && !tmoHit) |=> sl.sel;
   endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("extended select dropped");

   property p_tmo_time;
      @(posedge ref_clk) disable iff (srst)
      tmo |-> ($past(tmoCnt) == `CNT_W'(`TMO_CYC - 1));
   endproperty
   a_tmo_time: assert property (p_tmo_time) else $error("timeout at wrong count");
endmodule

// *** rtl/slot_if.sv ***
`timescale 1ns/10ps
interface slot_if;
   import ipc_pkg::*;
   slot_ctl_t ctl;
   logic      tick;
   logic      start;
   logic      ackSeen;
   logic      sel;
   logic      done;
   logic      timedOut;
   modport ctrl (output ctl, tick, start, ackSeen, input sel, done, timedOut);
   modport eng  (input ctl, tick, start, ackSeen, output sel, done, timedOut);
endinterface
